// *** rtl/csm_core_regs.sv ***
`timescale 1ns/1ps
module csm_core_regs (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    // Stack request from the sequencer
    input  wire csm_pkg::csm_op_t  stk_op,
    input  wire logic              stk_user,
    input  wire logic              stk_word,
    input  wire logic [15:0]       stk_wdata,
    // Stack memory access
    output logic                   mem_req,
    output logic                   mem_we,
    output logic [15:0]            mem_addr,
    output logic [15:0]            mem_wdata,
    output logic                   mem_word,
    output logic                   mem_internal,
    output logic                   mem_data_space,
    // Flag update from the ALU
    input  wire csm_pkg::csm_fop_t flag_op,
    input  wire logic              alu_word,
    input  wire logic [15:0]       alu_result,
    input  wire logic              alu_carry,
    input  wire logic              alu_ovf,
    input  wire logic              alu_half,
    input  wire logic              flag_restore,
    input  wire logic [7:0]        flag_restore_val,
    // Flags and mode outputs
    output logic [7:0]             flags_out,
    output logic                   data_space_sel,
    // Clocking
    input  wire logic              oscillator_input,
    output logic                   internal_clock,
    output logic                   cpu_clk_en,
    // Bus request and port float
    input  wire logic              bus_req_pin,
    output logic                   bus_req_grant,
    input  wire logic [7:0]        p0_addr_mux,
    input  wire logic [7:0]        p1_addr_mux,
    output logic [7:0]             p0_oe_mask,
    output logic [7:0]             p1_oe_mask,
    output logic [2:0]             nest_level
);
    typedef struct packed {
        logic [7:0]  mode;
        logic [7:0]  flags;
        logic [15:0] user_stack_internal;
        logic [15:0] ssp;
        logic [7:0]  rdata;
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        word;
        logic        internal;
        logic        dspace;
        logic [1:0]  osc_sync;
        logic        osc_prev;
        logic        halve_tgl;
        logic        clk_en;
        logic        int_en;
        logic [1:0]  brq_sync;
        logic        brq_grant;
        logic [7:0]  p0_mask;
        logic [7:0]  p1_mask;
        logic [2:0]  nest;
    } csm_st_t;
    csm_st_t st_reg;
    csm_st_t st_next;
    logic    osc_en;
    logic    div_en;

    csm_clkdiv u_div (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .en_in    (osc_en),
        .ratio_m1 (st_reg.mode[csm_pkg::MODE_PRS_LSB +: 3]),
        .en_out   (div_en)
    );

    always_comb begin
        logic        is_user;
        logic        is_int;
        logic        push;
        logic        pop;
        logic [15:0] sp;
        logic [15:0] step;
        logic [15:0] res;
        logic        msb;
        logic        zero;
        logic [7:0]  f;
        is_user = 1'b0;
        is_int = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        sp = 16'h0000;
        step = 16'h0000;
        res = 16'h0000;
        msb = 1'b0;
        zero = 1'b0;
        f = 8'h00;
        st_next = st_reg;
        st_next.req = 1'b0;
        st_next.we = 1'b0;
        // Oscillator edge sampling and halving
        st_next.osc_sync = {st_reg.osc_sync[0], oscillator_input};
        st_next.osc_prev = st_reg.osc_sync[1];
        osc_en = 1'b0;
        if (st_reg.osc_sync[1] && !st_reg.osc_prev) begin
            if (st_reg.mode[csm_pkg::MODE_HALVE_BIT]) begin
                st_next.halve_tgl = !st_reg.halve_tgl;
                osc_en = st_reg.halve_tgl;
            end else begin
                osc_en = 1'b1;
            end
        end
        // Internal clock runs at the (optionally halved) oscillator rate
        st_next.int_en = osc_en;
        st_next.clk_en = div_en;
        // Bus request gating
        st_next.brq_sync = {st_reg.brq_sync[0], bus_req_pin};
        st_next.brq_grant = st_reg.brq_sync[1] && st_reg.mode[csm_pkg::MODE_BRQ_BIT];
        // Float only the multiplexed address/data lines
        if (st_reg.mode[csm_pkg::MODE_FLOAT_BIT]) begin
            st_next.p0_mask = p0_addr_mux;
            st_next.p1_mask = p1_addr_mux;
        end else begin
            st_next.p0_mask = 8'h00;
            st_next.p1_mask = 8'h00;
        end
        // Stack operations
        is_int = (stk_op == csm_pkg::CSM_OP_INT) || (stk_op == csm_pkg::CSM_OP_IRET);
        push = (stk_op == csm_pkg::CSM_OP_PUSH) || (stk_op == csm_pkg::CSM_OP_CALL)
            || (stk_op == csm_pkg::CSM_OP_INT);
        pop = (stk_op == csm_pkg::CSM_OP_POP) || (stk_op == csm_pkg::CSM_OP_RET)
            || (stk_op == csm_pkg::CSM_OP_IRET);
        // Calls and interrupts always use the system stack
        is_user = stk_user && ((stk_op == csm_pkg::CSM_OP_PUSH)
            || (stk_op == csm_pkg::CSM_OP_POP));
        sp = is_user ? st_reg.user_stack_internal : st_reg.ssp;
        st_next.internal = is_user ? st_reg.mode[csm_pkg::MODE_USP_BIT]
                                   : st_reg.mode[csm_pkg::MODE_SSP_BIT];
        // Interrupt frame is flags plus PC: three bytes; calls move PC only
        step = (is_int) ? 16'h0003 : ((stk_word || stk_op == csm_pkg::CSM_OP_CALL
            || stk_op == csm_pkg::CSM_OP_RET) ? 16'h0002 : 16'h0001);
        if (push) begin
            sp = sp - step;
        end
        if (st_next.internal) begin
            sp[15:8] = is_user ? st_reg.user_stack_internal[15:8] : st_reg.ssp[15:8];
        end
        if (push || pop) begin
            st_next.req = 1'b1;
            st_next.we = push;
            st_next.addr = st_next.internal ? {8'h00, sp[7:0]} : sp;
            st_next.dspace = !st_next.internal
                || st_reg.flags[csm_pkg::FL_DP];
            st_next.word = stk_word || (stk_op != csm_pkg::CSM_OP_PUSH
                && stk_op != csm_pkg::CSM_OP_POP);
            st_next.wdata = (stk_op == csm_pkg::CSM_OP_INT)
                ? {st_reg.flags, stk_wdata[7:0]} : stk_wdata;
            if (pop) begin
                sp = sp + step;
            end
            if (st_next.internal) begin
                sp[15:8] = is_user ? st_reg.user_stack_internal[15:8] : st_reg.ssp[15:8];
            end
            if (is_user) begin
                st_next.user_stack_internal = sp;
            end else begin
                st_next.ssp = sp;
            end
        end
        // Nesting depth of saved flag copies
        if (stk_op == csm_pkg::CSM_OP_INT && st_reg.nest < 3'(csm_pkg::NEST_DEPTH)) begin
            st_next.nest = st_reg.nest + 3'h1;
        end else if (stk_op == csm_pkg::CSM_OP_IRET && st_reg.nest != 3'h0) begin
            st_next.nest = st_reg.nest - 3'h1;
        end
        // Flag updates
        f = st_reg.flags;
        res = alu_result;
        msb = alu_word ? res[15] : res[7];
        zero = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
        case (flag_op)
            csm_pkg::CSM_FOP_ADD, csm_pkg::CSM_FOP_SUB, csm_pkg::CSM_FOP_CMP: begin
                f[csm_pkg::FL_C] = alu_carry;
                f[csm_pkg::FL_Z] = zero;
                f[csm_pkg::FL_S] = msb;
                f[csm_pkg::FL_V] = alu_ovf;
                if (flag_op != csm_pkg::CSM_FOP_CMP) begin
                    f[csm_pkg::FL_DA] = (flag_op == csm_pkg::CSM_FOP_SUB);
                    if (!alu_word) begin
                        f[csm_pkg::FL_H] = alu_half;
                    end
                end
            end
            csm_pkg::CSM_FOP_SHIFT, csm_pkg::CSM_FOP_MULDIV: begin
                f[csm_pkg::FL_C] = alu_carry;
                f[csm_pkg::FL_Z] = zero;
                f[csm_pkg::FL_S] = msb;
                f[csm_pkg::FL_V] = alu_ovf;
            end
            csm_pkg::CSM_FOP_LOGIC, csm_pkg::CSM_FOP_INCDEC: begin
                f[csm_pkg::FL_Z] = zero;
                f[csm_pkg::FL_S] = msb;
                f[csm_pkg::FL_V] = alu_ovf;
            end
            csm_pkg::CSM_FOP_SCF: f[csm_pkg::FL_C] = 1'b1;
            csm_pkg::CSM_FOP_RCF: f[csm_pkg::FL_C] = 1'b0;
            csm_pkg::CSM_FOP_CCF: f[csm_pkg::FL_C] = !st_reg.flags[csm_pkg::FL_C];
            csm_pkg::CSM_FOP_SDM: f[csm_pkg::FL_DP] = 1'b1;
            csm_pkg::CSM_FOP_SPM: f[csm_pkg::FL_DP] = 1'b0;
            default: f = st_reg.flags;
        endcase
        if (flag_restore) begin
            f = flag_restore_val;
        end
        st_next.flags = f;
        // Software writes take priority over hardware updates
        if (reg_wr) begin
            case (reg_addr)
                csm_pkg::ADDR_FLAGS:    st_next.flags = reg_wdata;
                csm_pkg::ADDR_MODE:     st_next.mode = reg_wdata;
                csm_pkg::ADDR_USP_HIGH: st_next.user_stack_internal[15:8] = reg_wdata;
                csm_pkg::ADDR_USP_LOW:  st_next.user_stack_internal[7:0] = reg_wdata;
                csm_pkg::ADDR_SSP_HIGH: st_next.ssp[15:8] = reg_wdata;
                csm_pkg::ADDR_SSP_LOW:  st_next.ssp[7:0] = reg_wdata;
                default: st_next.rdata = st_reg.rdata;
            endcase
        end
        st_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                csm_pkg::ADDR_FLAGS:    st_next.rdata = st_reg.flags;
                csm_pkg::ADDR_MODE:     st_next.rdata = st_reg.mode;
                csm_pkg::ADDR_USP_HIGH: st_next.rdata = st_reg.user_stack_internal[15:8];
                csm_pkg::ADDR_USP_LOW:  st_next.rdata = st_reg.user_stack_internal[7:0];
                csm_pkg::ADDR_SSP_HIGH: st_next.rdata = st_reg.ssp[15:8];
                csm_pkg::ADDR_SSP_LOW:  st_next.rdata = st_reg.ssp[7:0];
                default:                st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_reg       <= '0;
            st_reg.mode  <= csm_pkg::MODE_RESET;
            st_reg.flags <= csm_pkg::FLAGS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata      = st_reg.rdata;
    assign mem_req        = st_reg.req;
    assign mem_we         = st_reg.we;
    assign mem_addr       = st_reg.addr;
    assign mem_wdata      = st_reg.wdata;
    assign mem_word       = st_reg.word;
    assign mem_internal   = st_reg.internal;
    assign mem_data_space = st_reg.dspace;
    assign flags_out      = st_reg.flags;
    assign data_space_sel = st_reg.flags[csm_pkg::FL_DP];
    assign internal_clock = st_reg.int_en;
    assign cpu_clk_en     = st_reg.clk_en;
    assign bus_req_grant  = st_reg.brq_grant;
    assign p0_oe_mask     = st_reg.p0_mask;
    assign p1_oe_mask     = st_reg.p1_mask;
    assign nest_level     = st_reg.nest;

    AST_MODE_RESET: assert property (@(posedge sys_clk)
        $rose(nrst) |-> st_reg.mode == 8'he0) else $error("mode reset wrong");
    AST_BRQ_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        bus_req_grant |-> $past(st_reg.mode[1])) else $error("grant while disabled");
    AST_POP_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (stk_op == csm_pkg::CSM_OP_POP) |=> mem_req && !mem_we) else $error("pop wrote");
    AST_EXT_DATA: assert property (@(posedge sys_clk) disable iff (!nrst)
        mem_req && !mem_internal |-> mem_data_space) else $error("ext stack not data");
    AST_SDM: assert property (@(posedge sys_clk) disable iff (!nrst || reg_wr || flag_restore)
        flag_op == csm_pkg::CSM_FOP_SDM |=> flags_out[0]) else $error("sdm failed");
    AST_FLOAT_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
        !st_reg.mode[0] |=> p0_oe_mask == 8'h00) else $error("float while clear");
    AST_NEST_MAX: assert property (@(posedge sys_clk) disable iff (!nrst)
        stk_op == csm_pkg::CSM_OP_INT && nest_level == 3'h7 |=> nest_level == 3'h7)
        else $error("nest overflow");
    AST_PUSH_PREDEC: assert property (@(posedge sys_clk) disable iff (!nrst || reg_wr)
        stk_op == csm_pkg::CSM_OP_PUSH && !stk_user && !stk_word && !st_reg.mode[7]
        |=> mem_addr == $past(st_reg.ssp) - 16'h0001) else $error("push not predecremented");
endmodule // csm_core_regs

// *** rtl/csm_pkg.sv ***
// Functional notes
// - Push pre-decrements the chosen stack pointer; pop reads then post-increments.
// - Pop never writes the stack locations it reads.
// - Interrupt entry saves flags and PC on system stack; call saves PC only.
// - Internal system stack uses low pointer byte only; external uses high:low.
// - User stack pointer is a pair; internal stack uses only the low byte.
// - Only explicit user-stack instructions move the user stack pointer.
// - External stack accesses always go to data memory.
// - Mode register resets to 1110 0000.
// - System stack location bit: 1 register file, 0 external data memory.
// - User stack location bit uses the same encoding.
// - Oscillator halving bit divides the oscillator clock by two.
// - Three-bit prescaler divides the CPU clock by one to eight.
// - External bus request accepted only while bus-request enable is set.
// - Float bit floats multiplexed address/data lines only; clearing does nothing.
// - Flags saved on interrupt entry, restored on return; seven nested copies.
// - Carry from arithmetic, shifts, rotates; bit 7 or 15; set/clear/complement ops.
// - Zero flag set when result is zero, for a wider instruction group.
// - Sign flag copies result bit 7 or bit 15.
// - Overflow flag marks a signed result out of range.
// - Decimal-adjust flag records last operation was add or subtract.
// - Half-carry captures carry or borrow at bit 3 of byte add/sub.
// - Memory-select flag set by select-data, cleared by select-program; user flag explicit.
package csm_pkg;
    localparam logic [7:0] ADDR_FLAGS     = 8'he7;
    localparam logic [7:0] ADDR_MODE      = 8'heb;
    localparam logic [7:0] ADDR_USP_HIGH  = 8'hec;
    localparam logic [7:0] ADDR_USP_LOW   = 8'hed;
    localparam logic [7:0] ADDR_SSP_HIGH  = 8'hee;
    localparam logic [7:0] ADDR_SSP_LOW   = 8'hef;
    localparam logic [7:0] MODE_RESET     = 8'he0;
    localparam int         MODE_SSP_BIT   = 7;
    localparam int         MODE_USP_BIT   = 6;
    localparam int         MODE_HALVE_BIT = 5;
    localparam int         MODE_PRS_LSB   = 2;
    localparam int         MODE_BRQ_BIT   = 1;
    localparam int         MODE_FLOAT_BIT = 0;
    localparam int         FL_C  = 7;
    localparam int         FL_Z  = 6;
    localparam int         FL_S  = 5;
    localparam int         FL_V  = 4;
    localparam int         FL_DA = 3;
    localparam int         FL_H  = 2;
    localparam int         FL_UF = 1;
    localparam int         FL_DP = 0;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam int         NEST_DEPTH     = 7;
    // Stack operation codes
    typedef enum logic [2:0] {
        CSM_OP_NONE,
        CSM_OP_PUSH,
        CSM_OP_POP,
        CSM_OP_CALL,
        CSM_OP_INT,
        CSM_OP_RET,
        CSM_OP_IRET
    } csm_op_t;
    // Flag update operation codes
    typedef enum logic [3:0] {
        CSM_FOP_NONE,
        CSM_FOP_ADD,
        CSM_FOP_SUB,
        CSM_FOP_CMP,
        CSM_FOP_LOGIC,
        CSM_FOP_INCDEC,
        CSM_FOP_SHIFT,
        CSM_FOP_MULDIV,
        CSM_FOP_SCF,
        CSM_FOP_RCF,
        CSM_FOP_CCF,
        CSM_FOP_SDM,
        CSM_FOP_SPM
    } csm_fop_t;
endpackage : csm_pkg

// *** rtl/csm_clkdiv.sv ***
`timescale 1ns/1ps
// Enable divider: one pulse every (ratio) input enables
module csm_clkdiv (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       en_in,
    input  wire logic [2:0] ratio_m1,
    // Output enable
    output logic            en_out
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       pulse;
    } csm_div_st_t;
    csm_div_st_t st_reg;
    csm_div_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.pulse = 1'b0;
        if (en_in) begin
            if (st_reg.cnt >= ratio_m1) begin
                st_next.cnt = 3'h0;
                st_next.pulse = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign en_out = st_reg.pulse;
endmodule // csm_clkdiv

// *** dv/cpu_stack_mode_flag_regs_test.sv ***
`timescale 1ns/1ps
module cpu_stack_mode_flag_regs_test;
    typedef struct {
        csm_pkg::csm_fop_t op;
        logic              w;
        logic [15:0]       res;
        logic [2:0]        cvh;
        logic [7:0]        mask;
        logic [7:0]        exp;
    } csm_tb_frow_t;
    typedef struct {
        logic [7:0] mode;
        int         lo_int;
        int         lo_cpu;
        logic [7:0] grant;
        logic [7:0] flt;
    } csm_tb_mrow_t;

    // Clock, reset, register port
    logic              sys_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [7:0]        reg_addr = 8'h00;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_rdata;
    // Stack side
    csm_pkg::csm_op_t  stk_op = csm_pkg::CSM_OP_NONE;
    logic              stk_user = 1'b0;
    logic              mem_req, mem_we, mem_word, mem_internal, mem_data_space;
    logic [15:0]       mem_addr, mem_wdata;
    // Flag side
    csm_pkg::csm_fop_t flag_op = csm_pkg::CSM_FOP_NONE;
    logic              alu_word = 1'b0;
    logic [15:0]       alu_result = 16'h0000;
    logic              alu_carry = 1'b0, alu_ovf = 1'b0, alu_half = 1'b0;
    logic              flag_restore = 1'b0;
    logic [7:0]        flag_restore_val = 8'h00;
    logic [7:0]        flags_out;
    logic              data_space_sel;
    // Clocking, bus request, port float
    logic              oscillator_input = 1'b0;
    logic              bus_req_pin = 1'b1;
    logic [1:0]        osc_cnt = 2'h0;
    logic              internal_clock, cpu_clk_en, bus_req_grant;
    logic [7:0]        p0_oe_mask, p1_oe_mask;
    logic [2:0]        nest_level;
    int                fails = 0;
    int                n_tests = 0;
    logic [7:0]        rd;

    csm_core_regs csm_core_regs_i (
        .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stk_op(stk_op),
        .stk_user(stk_user), .stk_word(1'b0), .stk_wdata(16'h00a5), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_word(mem_word),
        .mem_internal(mem_internal), .mem_data_space(mem_data_space), .flag_op(flag_op),
        .alu_word(alu_word), .alu_result(alu_result), .alu_carry(alu_carry),
        .alu_ovf(alu_ovf), .alu_half(alu_half), .flag_restore(flag_restore),
        .flag_restore_val(flag_restore_val), .flags_out(flags_out),
        .data_space_sel(data_space_sel), .oscillator_input(oscillator_input),
        .internal_clock(internal_clock), .cpu_clk_en(cpu_clk_en),
        .bus_req_pin(bus_req_pin), .bus_req_grant(bus_req_grant), .p0_addr_mux(8'h0f),
        .p1_addr_mux(8'hf0), .p0_oe_mask(p0_oe_mask), .p1_oe_mask(p1_oe_mask),
        .nest_level(nest_level)
    );

    always #25 sys_clk = ~sys_clk;

    // Oscillator with a period of four system clocks
    always @(posedge sys_clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        oscillator_input <= osc_cnt[1];
    end

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cnt(input string name, input int lo, input int got);
        n_tests++;
        if (got < lo || got > lo + 2) begin
            fails++;
            $display("mismatch %s expected %0d to %0d seen %0d", name, lo, lo + 2, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // One stack command, then the memory access it launches
    task automatic stk(input csm_pkg::csm_op_t op, input logic u, input logic [15:0] ea,
                       input logic [7:0] ewe);
        @(posedge sys_clk);
        stk_op <= op;
        stk_user <= u;
        @(posedge sys_clk);
        stk_op <= csm_pkg::CSM_OP_NONE;
        #1;
        chk8("mem_req", 8'h01, {7'h00, mem_req});
        chk8("mem_we", ewe, {7'h00, mem_we});
        chk16("mem_addr", ea, mem_addr);
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] e);
        reg_read(a, rd);
        chk8(name, e, rd);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    logic [7:0] rrows[6][3] = '{'{8'hec, 8'h11, 8'h11}, '{8'hed, 8'hdf, 8'hdf},
        '{8'hee, 8'h00, 8'h00}, '{8'hef, 8'hdc, 8'hdc}, '{8'he7, 8'h02, 8'h02},
        '{8'he8, 8'h55, 8'h00}};
    csm_tb_frow_t frows[13] = '{
        '{csm_pkg::CSM_FOP_ADD,    1'b0, 16'h0080, 3'b011, 8'hf6, 8'h36},
        '{csm_pkg::CSM_FOP_SUB,    1'b1, 16'h8000, 3'b100, 8'hf2, 8'ha2},
        '{csm_pkg::CSM_FOP_ADD,    1'b0, 16'h0100, 3'b100, 8'he2, 8'hc2},
        '{csm_pkg::CSM_FOP_LOGIC,  1'b0, 16'h0000, 3'b000, 8'he2, 8'hc2},
        '{csm_pkg::CSM_FOP_RCF,    1'b0, 16'h0000, 3'b000, 8'h82, 8'h02},
        '{csm_pkg::CSM_FOP_SCF,    1'b0, 16'h0000, 3'b000, 8'h82, 8'h82},
        '{csm_pkg::CSM_FOP_CCF,    1'b0, 16'h0000, 3'b000, 8'h82, 8'h02},
        '{csm_pkg::CSM_FOP_SDM,    1'b0, 16'h0000, 3'b000, 8'h03, 8'h03},
        '{csm_pkg::CSM_FOP_SPM,    1'b0, 16'h0000, 3'b000, 8'h03, 8'h02},
        '{csm_pkg::CSM_FOP_INCDEC, 1'b1, 16'h8000, 3'b000, 8'h62, 8'h22},
        '{csm_pkg::CSM_FOP_SHIFT,  1'b0, 16'h0001, 3'b100, 8'he2, 8'h82},
        '{csm_pkg::CSM_FOP_MULDIV, 1'b1, 16'h0000, 3'b000, 8'hc2, 8'h42},
        '{csm_pkg::CSM_FOP_CMP,    1'b0, 16'h0000, 3'b000, 8'hc2, 8'h42}};
    csm_tb_mrow_t mrows[4] = '{'{8'he0, 19, 19, 8'h00, 8'h00},
        '{8'hc3, 39, 39, 8'h01, 8'hff}, '{8'hcc, 39, 9, 8'h00, 8'h00},
        '{8'hdc, 39, 4, 8'h00, 8'h00}};

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        give_verdict();
    end

    initial begin
        int ni;
        int nc;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rchk("mode reset", csm_pkg::ADDR_MODE, 8'he0);
        chk8("flags reset", csm_pkg::FLAGS_RESET, flags_out);
        foreach (rrows[i]) begin
            reg_write(rrows[i][0], rrows[i][1]);
            rchk("register", rrows[i][0], rrows[i][2]);
        end
        stk(csm_pkg::CSM_OP_PUSH, 1'b0, 16'h00db, 8'h01);
        chk8("internal", 8'h01, {7'h00, mem_internal});
        rchk("ssp after push", csm_pkg::ADDR_SSP_LOW, 8'hdb);
        stk(csm_pkg::CSM_OP_POP, 1'b0, 16'h00db, 8'h00);
        rchk("ssp after pop", csm_pkg::ADDR_SSP_LOW, 8'hdc);
        stk(csm_pkg::CSM_OP_PUSH, 1'b1, 16'h00de, 8'h01);
        rchk("ssp untouched", csm_pkg::ADDR_SSP_LOW, 8'hdc);
        stk(csm_pkg::CSM_OP_CALL, 1'b0, 16'h00da, 8'h01);
        rchk("usp after call", csm_pkg::ADDR_USP_LOW, 8'hde);
        stk(csm_pkg::CSM_OP_INT, 1'b0, 16'h00d7, 8'h01);
        chk8("saved flags", 8'h02, mem_wdata[15:8]);
        chk8("nest level", 8'h01, {5'h00, nest_level});
        rchk("usp after int", csm_pkg::ADDR_USP_LOW, 8'hde);
        stk(csm_pkg::CSM_OP_IRET, 1'b0, 16'h00d7, 8'h00);
        chk8("nest after return", 8'h00, {5'h00, nest_level});
        stk(csm_pkg::CSM_OP_RET, 1'b0, 16'h00da, 8'h00);
        rchk("ssp after ret", csm_pkg::ADDR_SSP_LOW, 8'hdc);
        @(posedge sys_clk);
        flag_restore <= 1'b1;
        flag_restore_val <= 8'h81;
        @(posedge sys_clk);
        flag_restore <= 1'b0;
        #1 chk8("restored flags", 8'h81, flags_out);
        chk8("data select", 8'h01, {7'h00, data_space_sel});
        reg_write(csm_pkg::ADDR_FLAGS, 8'h02);
        // External stacks, program space selected
        reg_write(csm_pkg::ADDR_MODE, 8'h20);
        reg_write(csm_pkg::ADDR_SSP_HIGH, 8'h12);
        reg_write(csm_pkg::ADDR_SSP_LOW, 8'h34);
        stk(csm_pkg::CSM_OP_PUSH, 1'b0, 16'h1233, 8'h01);
        chk8("external", 8'h00, {7'h00, mem_internal});
        chk8("data space", 8'h01, {7'h00, mem_data_space});
        reg_write(csm_pkg::ADDR_USP_HIGH, 8'hab);
        reg_write(csm_pkg::ADDR_USP_LOW, 8'hcd);
        stk(csm_pkg::CSM_OP_PUSH, 1'b1, 16'habcc, 8'h01);
        chk8("user external", 8'h00, {7'h00, mem_internal});
        foreach (frows[i]) begin
            @(posedge sys_clk);
            flag_op <= frows[i].op;
            alu_word <= frows[i].w;
            alu_result <= frows[i].res;
            {alu_carry, alu_ovf, alu_half} <= frows[i].cvh;
            @(posedge sys_clk);
            flag_op <= csm_pkg::CSM_FOP_NONE;
            #1 chk8("flags", frows[i].exp, flags_out & frows[i].mask);
            if (i == 0)
                chk8("da after add", 8'h00, {7'h00, flags_out[csm_pkg::FL_DA]});
            if (i == 1)
                chk8("da after sub", 8'h01, {7'h00, flags_out[csm_pkg::FL_DA]});
        end
        foreach (mrows[i]) begin
            reg_write(csm_pkg::ADDR_MODE, mrows[i].mode);
            rchk("mode", csm_pkg::ADDR_MODE, mrows[i].mode);
            repeat (8) @(posedge sys_clk);
            ni = 0;
            nc = 0;
            repeat (160) begin
                @(posedge sys_clk);
                ni += int'(internal_clock);
                nc += int'(cpu_clk_en);
            end
            chk_cnt("internal clock", mrows[i].lo_int, ni);
            chk_cnt("cpu clock", mrows[i].lo_cpu, nc);
            chk8("grant", mrows[i].grant, {7'h00, bus_req_grant});
            chk8("p0 float", mrows[i].flt & 8'h0f, p0_oe_mask);
            chk8("p1 float", mrows[i].flt & 8'hf0, p1_oe_mask);
        end
        // Request enabled but pin released: no grant
        bus_req_pin <= 1'b0;
        reg_write(csm_pkg::ADDR_MODE, 8'he2);
        repeat (4) @(posedge sys_clk);
        #1 chk8("grant pin low", 8'h00, {7'h00, bus_req_grant});
        // Eight interrupts in a row: the nesting count stops at seven
        repeat (8) begin
            @(posedge sys_clk);
            stk_op <= csm_pkg::CSM_OP_INT;
        end
        @(posedge sys_clk);
        stk_op <= csm_pkg::CSM_OP_NONE;
        #1 chk8("nest saturates", 8'h07, {5'h00, nest_level});
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rchk("mode second reset", csm_pkg::ADDR_MODE, 8'he0);
        give_verdict();
    end
endmodule // cpu_stack_mode_flag_regs_test
